// ---- sim/fpff_checker.sv ----
// Port checks for the phase and FIFO flow block
`timescale 1ns/100ps
`default_nettype none
module fpff_checker
	import fpff_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic host_reset_pin_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic terminal_count_strobe,
	input wire logic dma_request,
	input wire logic drive_poll_en,
	input wire logic power_down,
	input wire logic [7:0] cmd_byte,
	input wire logic cmd_strobe,
	input wire logic core_byte_ack,
	input wire logic core_cmd_last,
	input wire logic result_take
);
	default clocking main_clk @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	logic acc;
	logic data_wr;
	logic data_rd;
	logic [7:0] wr_low;
	assign acc = psel && penable && pready;
	assign data_wr = acc && pwrite && paddr == FPFF_OFS_DATA;
	assign data_rd = acc && !pwrite && paddr == FPFF_OFS_DATA;
	assign wr_low = pwdata[7:0];
	a_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_cmd_cause: assert property (cmd_strobe |-> $past(data_wr))
		else $error("strobe without data write");
	a_cmd_value: assert property (cmd_strobe |-> cmd_byte == $past(wr_low))
		else $error("command byte differs from written byte");
	a_one_strobe: assert property (cmd_strobe ##1 (!core_byte_ack && !core_cmd_last) [*4]
		|=> !cmd_strobe)
		else $error("second byte taken without acknowledge");
	a_term_stop: assert property ($rose(terminal_count_strobe) |-> ##[1:5] !dma_request)
		else $error("request kept after terminal count");
	a_take_cause: assert property (result_take |-> $past(data_rd))
		else $error("result taken without data read");
	a_rate_reset: assert property (acc && pwrite && paddr == FPFF_OFS_RATE && pwdata[0]
		|-> ##[1:4] !drive_poll_en)
		else $error("rate reset had no effect");
	a_held_reset: assert property (acc && pwrite && paddr == FPFF_OFS_DIGOUT && pwdata[0]
		|-> ##[1:3] (!drive_poll_en && !power_down))
		else $error("held reset had no effect");
	a_pin_reset: assert property (!host_reset_pin_n [*6] |-> !drive_poll_en && !power_down)
		else $error("pin reset had no effect");
	c_strobe: cover property (cmd_strobe);
	c_take: cover property (result_take);
	c_dreq: cover property ($rose(dma_request));
endmodule
bind fpff_top fpff_checker u_fpff_checker (.clock, .rst_n, .host_reset_pin_n, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .terminal_count_strobe, .dma_request, .drive_poll_en,
	.power_down, .cmd_byte, .cmd_strobe, .core_byte_ack, .core_cmd_last, .result_take);
`default_nettype wire

// ---- sim/fpff_host_model.sv ----
// Host processor model: APB master whose send task polls status before each command byte
`timescale 1ns/100ps
`default_nettype none
module fpff_host_model
	import fpff_pkg::*;
(
	input wire logic clock,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	output logic hang
);
	logic [31:0] rdata;
	logic rerr;
	initial
	begin
		{psel, penable, pwrite, hang} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 32);
		if (n >= 32)
			hang <= 1'b1;
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines must not look like a held request
		paddr <= ~a;
		pwdata <= ~d;
	endtask
	task automatic poll(input logic [1:0] want);
		int n;
		for (n = 0; n < 64; n++)
		begin
			xfer(1'b0, FPFF_OFS_MSR, 32'h0);
			if ({rdata[FPFF_MSR_DIR_BIT], rdata[FPFF_MSR_REQ_BIT]} === want)
				break;
		end
		if (n == 64)
			hang <= 1'b1;
	endtask
	task automatic send(input logic [7:0] b);
		poll(2'h1);
		xfer(1'b1, FPFF_OFS_DATA, {24'h0, b});
	endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the phase and FIFO flow block
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import fpff_pkg::*;
;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} fpff_row_t;
	logic clock, rst_n, host_reset_pin_n, terminal_count_strobe, core_byte_ack, core_cmd_last;
	logic core_cmd_illegal, core_has_exec, core_exec_read, core_density_high, result_last;
	logic disk_put, disk_take, sector_end, track_end, psel, penable, pwrite, pready, pslverr;
	logic dma_request, controller_interrupt_out, density_select, drive_poll_en, power_down;
	logic cmd_strobe, result_take, hang;
	logic [7:0] disk_byte, result_data, cmd_byte, disk_data, paddr;
	logic [31:0] pwdata, prdata, v;
	int miscompares, checks, strobes, takes, i;
	fpff_row_t rows [6];
	fpff_top #(.DEPTH(FPFF_FIFO_DEPTH)) u_fpff_top (.clock, .rst_n, .host_reset_pin_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .terminal_count_strobe,
		.dma_request, .controller_interrupt_out, .density_select, .drive_poll_en, .power_down,
		.cmd_byte, .cmd_strobe, .core_byte_ack, .core_cmd_last, .core_cmd_illegal, .core_has_exec,
		.core_exec_read, .core_density_high, .result_data, .result_last, .result_take, .disk_put,
		.disk_byte, .disk_take, .disk_data, .sector_end, .track_end);
	fpff_host_model u_fpff_host_model (.clock, .prdata, .pready, .pslverr, .psel, .penable,
		.pwrite, .paddr, .pwdata, .hang);
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a);
		u_fpff_host_model.xfer(1'b0, a, 32'h0);
		v = u_fpff_host_model.rdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_fpff_host_model.xfer(1'b1, a, d);
	endtask
	task automatic wt(input int k, input logic x);
		int n;
		for (n = 0; n < 64; n++)
		begin
			@(posedge clock);
			if ((k == 0 ? dma_request : k == 1 ? controller_interrupt_out : drive_poll_en) === x)
				break;
		end
		if (n == 64)
		begin
			miscompares++;
			final_report();
		end
	endtask
	task automatic pulse(input int k);
		@(posedge clock);
		case (k)
			0: core_byte_ack <= 1'b1;
			1: core_cmd_last <= 1'b1;
			2: disk_put <= 1'b1;
			3: disk_take <= 1'b1;
			4: sector_end <= 1'b1;
			5: track_end <= 1'b1;
			7: core_cmd_illegal <= 1'b1;
			default: terminal_count_strobe <= 1'b1;
		endcase
		@(posedge clock);
		{core_byte_ack, core_cmd_last, disk_put, disk_take, sector_end, track_end} <= 6'h00;
		terminal_count_strobe <= 1'b0;
		core_cmd_illegal <= 1'b0;
	endtask
	always @(posedge clock)
	begin
		if (cmd_strobe === 1'b1)
			strobes++;
		if (result_take === 1'b1)
			takes++;
	end
	always @(posedge hang)
	begin
		miscompares++;
		final_report();
	end
	initial
	begin
		repeat (60000) @(posedge clock);
		miscompares++;
		final_report();
	end
	initial
	begin
		{core_byte_ack, core_cmd_last, core_cmd_illegal, core_has_exec, core_exec_read} = 5'h00;
		{result_last, disk_put, disk_take, sector_end, track_end, terminal_count_strobe} = 6'h00;
		{disk_byte, result_data} = 16'h0000;
		core_density_high = 1'b1;
		host_reset_pin_n = 1'b1;
		rst_n = 1'b0;
		rows = '{'{FPFF_OFS_SETUP, 32'h1, 32'h1, 1'b0}, '{FPFF_OFS_SETUP, 32'h0, 32'h0, 1'b0},
			'{FPFF_OFS_MODE, 32'hE, 32'hE, 1'b0}, '{FPFF_OFS_MODE, 32'h2, 32'h2, 1'b0},
			'{FPFF_OFS_CONFIG, 32'h13, 32'h13, 1'b0}, '{8'h1C, 32'hFF, 32'h0, 1'b1}};
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		rd(FPFF_OFS_DIGOUT);
		chk("held reset", 32'h1, v & 32'h3);
		chk("poll in reset", 32'h0, drive_poll_en);
		wr(FPFF_OFS_DIGOUT, 32'h2);
		for (i = 0; i < 6; i++)
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk("readback", rows[i].e, v);
			chk("error", rows[i].err, u_fpff_host_model.rerr);
		end
		rd(FPFF_OFS_MSR);
		chk("idle status", 32'h1, v & 32'h7);
		u_fpff_host_model.send(8'h46);
		rd(FPFF_OFS_MSR);
		chk("request after byte", 32'h0, v & 32'h1);
		chk("command byte", 32'h46, cmd_byte);
		wr(FPFF_OFS_DATA, 32'h99);
		pulse(0);
		u_fpff_host_model.send(8'h01);
		rd(FPFF_OFS_MSR);
		chk("strobes", 32'h2, strobes);
		{core_has_exec, core_exec_read} <= 2'h3;
		pulse(1);
		// Threshold parameter 3 gives 4, so service is due at 12 bytes
		for (i = 0; i < 12; i++)
		begin
			rd(FPFF_OFS_MSR);
			chk("read request", 32'h0, v & 32'h1);
			disk_byte <= 8'h10 + 8'(i);
			pulse(2);
		end
		// Level reached: request and flag follow two cycles later
		repeat (2) @(posedge clock);
		rd(FPFF_OFS_MSR);
		chk("read request full", 32'h1, v & 32'h1);
		chk("read irq", 32'h1, controller_interrupt_out);
		for (i = 0; i < 12; i++)
		begin
			rd(FPFF_OFS_DATA);
			chk("fifo byte", 32'h10 + i, v);
		end
		rd(FPFF_OFS_MSR);
		chk("empty request", 32'h0, v & 32'h1);
		chk("empty irq", 32'h0, controller_interrupt_out);
		pulse(5);
		wt(1, 1'b1);
		rd(FPFF_OFS_MSR);
		chk("result status", 32'h3, v & 32'h3);
		result_data <= 8'h5A;
		rd(FPFF_OFS_DATA);
		chk("result", 32'h5A, v);
		result_last <= 1'b1;
		result_data <= 8'hA5;
		rd(FPFF_OFS_DATA);
		chk("last result", 32'hA5, v);
		rd(FPFF_OFS_MSR);
		chk("after results", 32'h1, v & 32'h7);
		chk("takes", 32'h2, takes);
		wr(FPFF_OFS_SETUP, 32'h1);
		core_exec_read <= 1'b0;
		u_fpff_host_model.send(8'h45);
		pulse(1);
		wt(0, 1'b1);
		for (i = 0; i < 16; i++)
			wr(FPFF_OFS_DATA, 32'h30 + i);
		repeat (2) @(posedge clock);
		chk("full request", 32'h0, dma_request);
		pulse(3);
		@(posedge clock);
		#1;
		chk("first out", 32'h30, disk_data);
		for (i = 1; i < 11; i++)
			pulse(3);
		repeat (2) @(posedge clock);
		chk("five left", 32'h0, dma_request);
		pulse(3);
		wt(0, 1'b1);
		pulse(6);
		wt(0, 1'b0);
		for (i = 0; i < 4; i++)
			pulse(3);
		chk("after count", 32'h0, dma_request);
		pulse(4);
		wt(1, 1'b1);
		rd(FPFF_OFS_MSR);
		chk("abnormal", 32'h1, (v >> FPFF_MSR_ABN_BIT) & 32'h1);
		rd(FPFF_OFS_DATA);
		rd(FPFF_OFS_MSR);
		chk("after write", 32'h1, v & 32'h7);
		wr(FPFF_OFS_CONFIG, 32'h40);
		rd(FPFF_OFS_CONFIG);
		chk("power down", 32'h1, power_down);
		wr(FPFF_OFS_RATE, 32'h1);
		wt(2, 1'b0);
		wt(2, 1'b1);
		rd(FPFF_OFS_RATE);
		chk("rate clears", 32'h0, v & 32'h1);
		rd(FPFF_OFS_CONFIG);
		chk("config cleared", 32'h0, v);
		chk("awake", 32'h0, power_down);
		wr(FPFF_OFS_DIGOUT, 32'h3);
		rd(FPFF_OFS_MSR);
		chk("held core", 32'h0, v & 32'h1);
		host_reset_pin_n <= 1'b0;
		repeat (8) @(posedge clock);
		host_reset_pin_n <= 1'b1;
		rd(FPFF_OFS_DIGOUT);
		chk("pin reset", 32'h1, v & 32'h3);
		rd(FPFF_OFS_SETUP);
		chk("setup kept", 32'h1, v);
		wr(FPFF_OFS_DIGOUT, 32'h2);
		for (i = 0; i < 4; i++)
		begin
			wr(FPFF_OFS_MODE, 32'(i << 2));
			repeat (2) @(posedge clock);
			chk("density", 32'(i != 3), density_select);
		end
		// Illegal command goes straight to the result phase with an interrupt
		u_fpff_host_model.send(8'h77);
		pulse(7);
		wt(1, 1'b1);
		rd(FPFF_OFS_MSR);
		chk("illegal result", 32'h3, v & 32'h3);
		final_report();
	end
endmodule
`default_nettype wire

// ---- verilog/fpff_pkg.sv ----
// Package with register map, field positions and reset values for the phase and FIFO flow block
package fpff_pkg;
	localparam logic [7:0] FPFF_OFS_DIGOUT = 8'h00;
	localparam logic [7:0] FPFF_OFS_RATE = 8'h04;
	localparam logic [7:0] FPFF_OFS_MSR = 8'h08;
	localparam logic [7:0] FPFF_OFS_DATA = 8'h0C;
	localparam logic [7:0] FPFF_OFS_SETUP = 8'h10;
	localparam logic [7:0] FPFF_OFS_CONFIG = 8'h14;
	localparam logic [7:0] FPFF_OFS_MODE = 8'h18;
	localparam int FPFF_DIGOUT_RST_BIT = 0;
	localparam int FPFF_DIGOUT_GATE_BIT = 1;
	localparam int FPFF_RATE_RST_BIT = 0;
	localparam int FPFF_SETUP_DMA_BIT = 0;
	localparam int FPFF_CFG_THR_LSB = 0;
	localparam int FPFF_CFG_FIFOEN_BIT = 4;
	localparam int FPFF_CFG_NOPOLL_BIT = 5;
	localparam int FPFF_CFG_PDOWN_BIT = 6;
	localparam int FPFF_MODE_BURST_BIT = 1;
	localparam int FPFF_MODE_LSB = 2;
	localparam int FPFF_MSR_REQ_BIT = 0;
	localparam int FPFF_MSR_DIR_BIT = 1;
	localparam int FPFF_MSR_BUSY_BIT = 2;
	localparam int FPFF_MSR_EXEC_BIT = 3;
	localparam int FPFF_MSR_ABN_BIT = 4;
	localparam int FPFF_MSR_DREQ_BIT = 5;
	localparam logic [1:0] FPFF_DIGOUT_RESET_VAL = 2'h1;
	localparam logic [6:0] FPFF_CONFIG_RESET_VAL = 7'h00;
	localparam logic [3:0] FPFF_MODE_RESET_VAL = 4'h0;
	localparam logic FPFF_SETUP_RESET_VAL = 1'b0;
	localparam int FPFF_FIFO_DEPTH = 16;
	localparam logic [1:0] FPFF_MODE_FIRST = 2'h0;
	localparam logic [1:0] FPFF_MODE_SECOND = 2'h1;
	localparam logic [1:0] FPFF_MODE_THIRD = 2'h3;
	typedef enum logic [4:0] {
		FPFF_PH_RESET = 5'h01,
		FPFF_PH_CMD = 5'h02,
		FPFF_PH_WAIT = 5'h04,
		FPFF_PH_EXEC = 5'h08,
		FPFF_PH_RES = 5'h10
	} fpff_phase_t;
endpackage

// ---- verilog/fpff_top.sv ----
// Command, execution and result sequencing with FIFO flow control behind an APB slave
`timescale 1ns/100ps
`default_nettype none
module fpff_top
	import fpff_pkg::*;
#(
	parameter int DEPTH = FPFF_FIFO_DEPTH
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic host_reset_pin_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic terminal_count_strobe,
	output logic dma_request,
	output logic controller_interrupt_out,
	output logic density_select,
	output logic drive_poll_en,
	output logic power_down,
	output logic [7:0] cmd_byte,
	output logic cmd_strobe,
	input wire logic core_byte_ack,
	input wire logic core_cmd_last,
	input wire logic core_cmd_illegal,
	input wire logic core_has_exec,
	input wire logic core_exec_read,
	input wire logic core_density_high,
	input wire logic [7:0] result_data,
	input wire logic result_last,
	output logic result_take,
	input wire logic disk_put,
	input wire logic [7:0] disk_byte,
	input wire logic disk_take,
	output logic [7:0] disk_data,
	input wire logic sector_end,
	input wire logic track_end
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

	fpff_phase_t phase_r;
	logic [2:0] prst_sync_r;
	logic [1:0] term_sync_r;
	logic term_seen_r;
	logic [1:0] digital_output_reg_r;
	logic rate_rst_r;
	logic setup_dma_r;
	logic [6:0] config_r;
	logic [3:0] mode_r;
	logic busy_r;
	logic exec_read_r;
	logic req_flag_r;
	logic irq_r;
	logic dreq_r;
	logic gap_r;
	logic sect_seen_r;
	logic done_pend_r;
	logic abnormal_r;
	logic [7:0] mem_r [DEPTH];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [CW-1:0] cnt_r;
	logic pin_rst;
	logic core_rst;
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic data_wr;
	logic data_rd;
	logic in_exec;
	logic fifo_en;
	logic [CW-1:0] cap;
	logic push;
	logic pop;
	logic xrun;
	logic gate_en;
	logic term_now;

	// Bytes that must be held before a read-direction request fires
	function automatic logic [CW-1:0] read_level(input logic en, input logic [3:0] thr);
		logic [CW-1:0] lvl;
		lvl = DEPTH_C - CW'(thr) - CW'(1);
		if (!en || lvl == '0)
			lvl = CW'(1);
		return lvl;
	endfunction

	// Bytes left in FIFO at which a write-direction request returns
	function automatic logic [CW-1:0] write_level(input logic en, input logic [3:0] thr);
		return en ? CW'(thr) + CW'(1) : '0;
	endfunction

	assign pin_rst = prst_sync_r[2];
	assign core_rst = pin_rst | digital_output_reg_r[FPFF_DIGOUT_RST_BIT] | rate_rst_r;
	assign acc = psel & penable & pready;
	assign wr_acc = acc & pwrite;
	assign rd_acc = acc & ~pwrite;
	assign data_wr = wr_acc & (paddr == FPFF_OFS_DATA);
	assign data_rd = rd_acc & (paddr == FPFF_OFS_DATA);
	assign in_exec = (phase_r == FPFF_PH_EXEC);
	// FIFO stays one byte deep outside execution and until configured
	assign fifo_en = config_r[FPFF_CFG_FIFOEN_BIT] & in_exec;
	assign cap = fifo_en ? DEPTH_C : CW'(1);
	assign push = in_exec & (exec_read_r ? disk_put : data_wr) & (cnt_r != cap);
	assign pop = in_exec & (exec_read_r ? data_rd : disk_take) & (cnt_r != '0);
	assign xrun = in_exec & ((exec_read_r & disk_put & (cnt_r == cap))
		| (~exec_read_r & disk_take & (cnt_r == '0) & ~term_seen_r));
	assign gate_en = (mode_r[3:2] == FPFF_MODE_SECOND)
		| digital_output_reg_r[FPFF_DIGOUT_GATE_BIT];
	assign term_now = term_sync_r[1] & ~term_seen_r;

	// Pin reset is synchronised and delayed through three stages so release is clean
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			prst_sync_r <= 3'h7;
		else
			prst_sync_r <= {prst_sync_r[1], prst_sync_r[0], ~host_reset_pin_n};
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			term_sync_r <= 2'h0;
		else
			term_sync_r <= {term_sync_r[0], terminal_count_strobe};
	end

	// Setup register survives the pin reset; only power-on clears it
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			setup_dma_r <= FPFF_SETUP_RESET_VAL;
		else if (wr_acc && paddr == FPFF_OFS_SETUP)
			setup_dma_r <= pwdata[FPFF_SETUP_DMA_BIT];
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			digital_output_reg_r <= FPFF_DIGOUT_RESET_VAL;
			mode_r <= FPFF_MODE_RESET_VAL;
			rate_rst_r <= 1'b0;
		end
		else if (pin_rst)
		begin
			digital_output_reg_r <= FPFF_DIGOUT_RESET_VAL;
			mode_r <= FPFF_MODE_RESET_VAL;
			rate_rst_r <= 1'b0;
		end
		else
		begin
			rate_rst_r <= 1'b0;
			if (wr_acc && paddr == FPFF_OFS_DIGOUT)
				digital_output_reg_r <= pwdata[1:0];
			if (wr_acc && paddr == FPFF_OFS_RATE)
				rate_rst_r <= pwdata[FPFF_RATE_RST_BIT];
			if (wr_acc && paddr == FPFF_OFS_MODE)
				mode_r <= {pwdata[3:2], pwdata[FPFF_MODE_BURST_BIT], 1'b0};
		end
	end

	// Configuration is wiped by every reset: FIFO off, polling on, powered up
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			config_r <= FPFF_CONFIG_RESET_VAL;
		else if (core_rst)
			config_r <= FPFF_CONFIG_RESET_VAL;
		else if (wr_acc && paddr == FPFF_OFS_CONFIG)
			config_r <= pwdata[6:0];
	end

	// Phase sequencing
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_r <= FPFF_PH_RESET;
			busy_r <= 1'b0;
			exec_read_r <= 1'b0;
			cmd_byte <= 8'h00;
			cmd_strobe <= 1'b0;
			result_take <= 1'b0;
		end
		else if (core_rst)
		begin
			phase_r <= FPFF_PH_RESET;
			busy_r <= 1'b0;
			cmd_strobe <= 1'b0;
			result_take <= 1'b0;
		end
		else
		begin
			cmd_strobe <= 1'b0;
			result_take <= 1'b0;
			case (phase_r)
				FPFF_PH_RESET:
					phase_r <= FPFF_PH_CMD;
				FPFF_PH_CMD:
					if (data_wr)
					begin
						cmd_byte <= pwdata[7:0];
						cmd_strobe <= 1'b1;
						busy_r <= 1'b1;
						phase_r <= FPFF_PH_WAIT;
					end
				FPFF_PH_WAIT:
					if (core_cmd_illegal)
						phase_r <= FPFF_PH_RES;
					else if (core_cmd_last)
					begin
						exec_read_r <= core_exec_read;
						phase_r <= core_has_exec ? FPFF_PH_EXEC : FPFF_PH_RES;
					end
					else if (core_byte_ack)
						phase_r <= FPFF_PH_CMD;
				FPFF_PH_EXEC:
					if (xrun || (done_pend_r && cnt_r == '0))
						phase_r <= FPFF_PH_RES;
				FPFF_PH_RES:
					if (data_rd)
					begin
						result_take <= 1'b1;
						if (result_last)
						begin
							busy_r <= 1'b0;
							phase_r <= FPFF_PH_CMD;
						end
					end
				default:
					phase_r <= FPFF_PH_RESET;
			endcase
		end
	end

	// Termination tracking
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			term_seen_r <= 1'b0;
			sect_seen_r <= 1'b0;
			done_pend_r <= 1'b0;
			abnormal_r <= 1'b0;
		end
		else if (core_rst || phase_r == FPFF_PH_WAIT)
		begin
			term_seen_r <= 1'b0;
			sect_seen_r <= 1'b0;
			done_pend_r <= 1'b0;
			abnormal_r <= core_rst ? 1'b0 : abnormal_r & ~core_cmd_last;
		end
		else if (in_exec)
		begin
			if (term_now)
				term_seen_r <= 1'b1;
			if (sector_end)
				sect_seen_r <= 1'b1;
			else if (term_now)
				sect_seen_r <= 1'b0;
			// Host stopping before the sector ends still finishes it
			if (sector_end && (term_seen_r || term_now))
			begin
				done_pend_r <= 1'b1;
				abnormal_r <= term_seen_r & ~sect_seen_r;
			end
			if (track_end)
				done_pend_r <= 1'b1;
			if (xrun)
				abnormal_r <= 1'b1;
		end
	end

	// Data FIFO storage; DEPTH must be a power of two for pointer wrap
	always_ff @(posedge clock)
	begin
		if (push)
			mem_r[wp_r] <= exec_read_r ? disk_byte : pwdata[7:0];
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			disk_data <= 8'h00;
		end
		else if (core_rst || !in_exec || xrun)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= wp_r + PW'(1);
			if (pop)
				rp_r <= rp_r + PW'(1);
			if (pop && !exec_read_r)
				disk_data <= mem_r[rp_r];
			if (push && !pop)
				cnt_r <= cnt_r + CW'(1);
			else if (pop && !push)
				cnt_r <= cnt_r - CW'(1);
		end
	end

	// Service request for host or DMA; a request may linger while the core drains
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			dreq_r <= 1'b0;
		else if (core_rst || !in_exec)
			dreq_r <= phase_r == FPFF_PH_WAIT && core_cmd_last && core_has_exec
				&& !core_exec_read && !core_rst;
		else if (exec_read_r)
		begin
			if (cnt_r == '0 || (pop && cnt_r == CW'(1)))
				dreq_r <= 1'b0;
			else if (cnt_r >= read_level(fifo_en, config_r[3:0]) || sect_seen_r)
				dreq_r <= 1'b1;
		end
		else
		begin
			if (term_seen_r || cnt_r == cap || (push && cnt_r + CW'(1) == cap))
				dreq_r <= 1'b0;
			else if (cnt_r <= write_level(fifo_en, config_r[3:0]))
				dreq_r <= 1'b1;
		end
	end

	// Single mode drops the DMA request for one cycle after each byte
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			gap_r <= 1'b0;
		else
			gap_r <= ~mode_r[1] & (push | pop) & (data_wr | data_rd);
	end

	// Host-visible request flag and interrupt
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_flag_r <= 1'b0;
			irq_r <= 1'b0;
		end
		else if (core_rst)
		begin
			req_flag_r <= 1'b0;
			irq_r <= 1'b0;
		end
		else
		begin
			case (phase_r)
				FPFF_PH_CMD:
				begin
					req_flag_r <= ~data_wr;
					irq_r <= 1'b0;
				end
				FPFF_PH_RES:
				begin
					req_flag_r <= ~(data_rd & result_last);
					if (data_rd)
						irq_r <= 1'b0;
				end
				FPFF_PH_EXEC:
				begin
					req_flag_r <= ~setup_dma_r & dreq_r;
					irq_r <= ~setup_dma_r & dreq_r;
				end
				FPFF_PH_WAIT:
				begin
					req_flag_r <= core_byte_ack & ~core_cmd_last & ~core_cmd_illegal;
					irq_r <= core_cmd_illegal | (core_cmd_last & ~core_has_exec);
				end
				default:
				begin
					req_flag_r <= 1'b0;
					irq_r <= 1'b0;
				end
			endcase
			if (in_exec && (xrun || (done_pend_r && cnt_r == '0)))
			begin
				req_flag_r <= 1'b1;
				irq_r <= 1'b1;
			end
		end
	end

	// Pin outputs
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dma_request <= 1'b0;
			controller_interrupt_out <= 1'b0;
			density_select <= 1'b0;
			drive_poll_en <= 1'b0;
			power_down <= 1'b0;
		end
		else
		begin
			dma_request <= setup_dma_r & in_exec & dreq_r & gate_en & ~gap_r
				& ~term_seen_r & ~term_now & ~core_rst;
			controller_interrupt_out <= irq_r & gate_en;
			if (mode_r[3:2] == FPFF_MODE_THIRD)
				density_select <= ~core_density_high;
			else
				density_select <= core_density_high;
			drive_poll_en <= ~core_rst & ~config_r[FPFF_CFG_NOPOLL_BIT];
			power_down <= ~core_rst & config_r[FPFF_CFG_PDOWN_BIT];
		end
	end

	// APB slave: no wait cycles, read data prepared in the setup cycle
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel && !penable)
			begin
				prdata <= 32'h0000_0000;
				case (paddr)
					FPFF_OFS_DIGOUT:
						prdata[1:0] <= digital_output_reg_r;
					FPFF_OFS_RATE:
						prdata[0] <= rate_rst_r;
					FPFF_OFS_MSR:
					begin
						prdata[FPFF_MSR_REQ_BIT] <= req_flag_r;
						prdata[FPFF_MSR_DIR_BIT] <= (phase_r == FPFF_PH_RES)
							| (in_exec & exec_read_r);
						prdata[FPFF_MSR_BUSY_BIT] <= busy_r;
						prdata[FPFF_MSR_EXEC_BIT] <= in_exec;
						prdata[FPFF_MSR_ABN_BIT] <= abnormal_r;
						prdata[FPFF_MSR_DREQ_BIT] <= dma_request;
					end
					FPFF_OFS_DATA:
						if (phase_r == FPFF_PH_RES)
							prdata[7:0] <= result_data;
						else if (in_exec && cnt_r != '0)
							prdata[7:0] <= mem_r[rp_r];
					FPFF_OFS_SETUP:
						prdata[0] <= setup_dma_r;
					FPFF_OFS_CONFIG:
						prdata[6:0] <= config_r;
					FPFF_OFS_MODE:
						prdata[3:0] <= mode_r;
					default:
						pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule
`default_nettype wire
